// file: scf_front.sv
`timescale 1ns/1ps
module scf_front
  import scf_pkg::*;
#(
  parameter int unsigned HRST_CYCLES = HRST_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic power_good_in,
  input wire logic clock_dir_strap,
  input wire logic timer_osc_in,
  input wire logic kbd_reset_req,
  input wire logic io_wr_strobe,
  input wire logic [7:0] io_wr_addr,
  input wire logic [7:0] io_wr_data,
  input wire logic cycle_start,
  input wire logic mem_io_in,
  input wire logic data_ctl_in,
  input wire logic wr_rd_in,
  input wire logic low_region_n,
  input wire logic dma_cycle,
  input wire logic master_cycle,
  input wire logic [26:24] addr_hi_dma,
  input wire logic [16:8] addr_mid_dma,
  input wire logic [7:0] be_drive_n,
  input wire logic [7:0] byte_lane_enables_n_in,
  output logic [7:0] byte_lane_enables_n_out,
  output logic byte_lane_enables_n_oe,
  output logic [26:24] addr_hi_out,
  output logic [16:8] addr_mid_out,
  output logic addr_snoop_oe,
  output logic local_bus_clock_out,
  output logic local_bus_clock_oe,
  output logic timer_osc_div_out,
  output logic cpu_hard_reset_out,
  output logic warm_restart_out,
  output logic mem_ctl_enable,
  output logic [2:0] cycle_type,
  output logic shutdown_seen
);

  ////////////////////////////////////////////////////////////////
  // all state of the front end except the two pin synchronisers
  typedef struct packed {
    logic [31:0] hrst_cnt;
    logic hrst;
    logic strap_done;
    logic local_bus_clock_drive;
    logic local_bus_clock;
    logic [3:0] warm_cnt;
    logic warm;
    logic p92_bit;
    logic [2:0] osc_sh;
    logic [2:0] osc_cnt;
    logic osc_div;
    logic [2:0] ctype;
    logic shut;
    logic dram_s1;
    logic dram_s2;
  } scf_st_t;

  scf_st_t st_r;
  scf_st_t st_nxt;

  logic pg_sync;
  logic strap_sync;
  logic osc_rise;
  logic p92_write;
  logic p92_rise;
  logic shut_cyc;
  logic warm_trig;
  scf_cyc_t dec;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  scf_sync2 u_pg_sync (
    .clock(clock),
    .rstn(rstn),
    .d(power_good_in),
    .q(pg_sync)
  );

  // the strap pin is asynchronous as well; only a settled level is latched
  scf_sync2 u_strap_sync (
    .clock(clock),
    .rstn(rstn),
    .d(clock_dir_strap),
    .q(strap_sync)
  );

  ////////////////////////////////////////////////////////////////
  // bus status decode
  always_comb begin
    dec = scf_cyc_t'({mem_io_in, data_ctl_in, wr_rd_in});
  end

  // special cycle with byte lane 0 only marks shutdown
  assign shut_cyc = (dec == SCF_CYC_SPEC) && (byte_lane_enables_n_in == 8'hFE);

  ////////////////////////////////////////////////////////////////
  // warm restart sources
  assign p92_write = io_wr_strobe && (io_wr_addr == PORT92_ADDR);
  // only a 0 to 1 step of the init bit counts, rewriting 1 does nothing
  assign p92_rise = p92_write && io_wr_data[PORT92_INIT_BIT] && !st_r.p92_bit;
  assign warm_trig = kbd_reset_req || p92_rise || (cycle_start && shut_cyc);

  ////////////////////////////////////////////////////////////////
  // oscillator edge from the sampled pin history
  assign osc_rise = st_r.osc_sh[1] && !st_r.osc_sh[2];

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;

    // reset ends only after power-good has been stable for the full hold time
    if (!pg_sync) begin
      st_nxt.hrst = 1'b1;
      st_nxt.hrst_cnt = '0;
    end else if (st_r.hrst) begin
      if (st_r.hrst_cnt >= HRST_CYCLES - 1) begin
        st_nxt.hrst = 1'b0;
      end else begin
        st_nxt.hrst_cnt = st_r.hrst_cnt + 32'h1;
      end
    end

    // strap followed while reset is active, frozen after the first release
    if (st_r.hrst && !st_r.strap_done) begin
      st_nxt.local_bus_clock_drive = strap_sync;
    end
    if (!st_r.hrst) begin
      st_nxt.strap_done = 1'b1;
    end

    st_nxt.local_bus_clock = !st_r.local_bus_clock;

    if (p92_write) begin
      st_nxt.p92_bit = io_wr_data[PORT92_INIT_BIT];
    end

    // retrigger restarts the full minimum width
    if (warm_trig && !st_r.hrst) begin
      st_nxt.warm = 1'b1;
      st_nxt.warm_cnt = 4'(WARM_MIN_CYC - 1);
    end else if (st_r.warm) begin
      if (st_r.warm_cnt == 4'h0) begin
        st_nxt.warm = 1'b0;
      end else begin
        st_nxt.warm_cnt = st_r.warm_cnt - 4'h1;
      end
    end

    // oscillator is slow against the clock, so edges are sampled
    st_nxt.osc_sh = {st_r.osc_sh[1:0], timer_osc_in};
    if (osc_rise) begin
      if (st_r.osc_cnt == 3'(OSC_HALF - 1)) begin
        st_nxt.osc_cnt = 3'h0;
        st_nxt.osc_div = !st_r.osc_div;
      end else begin
        st_nxt.osc_cnt = st_r.osc_cnt + 3'h1;
      end
    end

    if (cycle_start) begin
      st_nxt.ctype = 3'(dec);
      st_nxt.shut = shut_cyc;
    end else begin
      st_nxt.shut = 1'b0;
    end

    // low-region status is an asynchronous pin: two flops before the gate
    st_nxt.dram_s1 = low_region_n;
    st_nxt.dram_s2 = st_r.dram_s1;
  end

  // power-on state: hard reset held, low-region status taken as not asserted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.hrst <= 1'b1;
      st_r.dram_s1 <= 1'b1;
      st_r.dram_s2 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // reset and clock outputs
  assign cpu_hard_reset_out = st_r.hrst;
  assign warm_restart_out = st_r.warm;
  assign local_bus_clock_out = st_r.local_bus_clock;
  assign local_bus_clock_oe = st_r.local_bus_clock_drive && st_r.strap_done;
  assign timer_osc_div_out = st_r.osc_div;

  ////////////////////////////////////////////////////////////////
  // memory gate and cycle status
  assign mem_ctl_enable = !st_r.dram_s2;
  assign cycle_type = st_r.ctype;
  assign shutdown_seen = st_r.shut;

  ////////////////////////////////////////////////////////////////
  // pin direction; only the snoop lanes leave the chip, 23:17 and 7:0 have no driver
  assign addr_snoop_oe = dma_cycle;
  assign addr_hi_out = addr_hi_dma;
  assign addr_mid_out = addr_mid_dma;
  assign byte_lane_enables_n_oe = dma_cycle || master_cycle;
  assign byte_lane_enables_n_out = byte_lane_enables_n_oe ? be_drive_n : BE_IDLE_N;
endmodule : scf_front

// file: scf_pkg.sv
package scf_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned HRST_MIN_US = 1000;
  localparam int unsigned HRST_CYC = HRST_MIN_US * CLK_MHZ;
  localparam int unsigned WARM_MIN_CYC = 16;
  localparam int unsigned OSC_DIV = 12;
  localparam int unsigned OSC_HALF = OSC_DIV / 2;
  localparam logic [7:0] BE_IDLE_N = 8'hFF;
  localparam logic [7:0] PORT92_ADDR = 8'h92;
  localparam int unsigned PORT92_INIT_BIT = 0;
  typedef enum logic [2:0] {
    SCF_CYC_INTA  = 3'h0,
    SCF_CYC_SPEC  = 3'h1,
    SCF_CYC_IORD  = 3'h2,
    SCF_CYC_IOWR  = 3'h3,
    SCF_CYC_CODE  = 3'h4,
    SCF_CYC_RSVD  = 3'h5,
    SCF_CYC_MRD   = 3'h6,
    SCF_CYC_MWR   = 3'h7
  } scf_cyc_t;
endpackage : scf_pkg

// file: scf_sync2.sv
`timescale 1ns/1ps
module scf_sync2 (
  input wire logic clock,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } scf_sync_st_t;
  scf_sync_st_t st_r;
  scf_sync_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule : scf_sync2

// file: scf_front_assertions.sv
`timescale 1ns/1ps
module scf_front_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic power_good_in,
  input wire logic cycle_start,
  input wire logic mem_io_in,
  input wire logic data_ctl_in,
  input wire logic wr_rd_in,
  input wire logic low_region_n,
  input wire logic dma_cycle,
  input wire logic master_cycle,
  input wire logic byte_lane_enables_n_oe,
  input wire logic addr_snoop_oe,
  input wire logic local_bus_clock_out,
  input wire logic cpu_hard_reset_out,
  input wire logic warm_restart_out,
  input wire logic mem_ctl_enable,
  input wire logic [2:0] cycle_type
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  warm_min_len_a: assert property ($rose(warm_restart_out) |-> warm_restart_out [*8] ##1 warm_restart_out [*8])
    else $error("warm pulse short");
  warm_blocked_a: assert property ($past(cpu_hard_reset_out) |-> !$rose(warm_restart_out))
    else $error("warm during hard reset");
  hard_on_pg_a: assert property (!power_good_in |-> ##[1:3] cpu_hard_reset_out)
    else $error("hard reset missing");
  local_bus_clock_half_a: assert property ($past(rstn) |-> local_bus_clock_out != $past(local_bus_clock_out))
    else $error("local clock stalled");
  mem_gate_a: assert property ($past(rstn, 2) |-> mem_ctl_enable == !$past(low_region_n, 2))
    else $error("memory enable wrong");
  cyc_decode_a: assert property (cycle_start |=> cycle_type == $past({mem_io_in, data_ctl_in, wr_rd_in}))
    else $error("cycle type wrong");
  be_dir_a: assert property (byte_lane_enables_n_oe == (dma_cycle || master_cycle))
    else $error("byte enable direction");
  snoop_dir_a: assert property (addr_snoop_oe == dma_cycle)
    else $error("address direction");
endmodule : scf_front_assertions
bind scf_front scf_front_assertions chk_u (.*);

// file: scf_cpu_model.sv
`timescale 1ns/1ps
module scf_cpu_model (
  input wire logic clock,
  input wire logic req,
  input wire logic [10:0] bus,
  output logic cycle_start,
  output logic mem_io_in,
  output logic data_ctl_in,
  output logic wr_rd_in,
  output logic [7:0] byte_lane_enables_n_in
);
  logic [10:0] last_r = '0;
  initial {cycle_start, mem_io_in, data_ctl_in, wr_rd_in, byte_lane_enables_n_in} = '0;
  // status is meaningless between cycles, so show the inverse of the last one
  always @(posedge clock) begin
    cycle_start <= req;
    last_r <= req ? bus : last_r;
    {mem_io_in, data_ctl_in, wr_rd_in, byte_lane_enables_n_in} <= req ? bus : ~last_r;
  end
endmodule : scf_cpu_model

// file: scf_front_test.sv
`timescale 1ns/1ps
module scf_front_test;
  logic clock = 0, rstn = 0, power_good_in = 0, clock_dir_strap = 1, kbd_reset_req = 0, io_wr_strobe = 0;
  logic dma_cycle = 0, master_cycle = 0, low_region_n = 1, req = 0;
  logic [7:0] io_wr_addr = 8'h92, io_wr_data = 0, be_drive_n = 0, byte_lane_enables_n_in, byte_lane_enables_n_out;
  logic [10:0] bus = 0;
  logic [2:0] oc = 0, addr_hi_dma = 0, cycle_type, addr_hi_out;
  logic [8:0] addr_mid_dma = 0, addr_mid_out;
  logic cycle_start, mem_io_in, data_ctl_in, wr_rd_in, byte_lane_enables_n_oe, addr_snoop_oe, local_bus_clock_out;
  logic local_bus_clock_oe, timer_osc_div_out, cpu_hard_reset_out, warm_restart_out, mem_ctl_enable, shutdown_seen;
  wire timer_osc_in = oc[2];
  int fails = 0, n_tests = 0;
  bit [31:0] sd = 32'hB0FA;
  always #2 clock = ~clock;
  // oscillator kept well under half the master rate
  always @(posedge clock) oc <= oc + 3'h1;
  scf_cpu_model cpu_u (.*);
  scf_front #(.HRST_CYCLES(20)) dut_u (.*);
  ////////////////////////////////////////////////////////////
  function automatic bit [31:0] lfsr(bit [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wr92(logic [7:0] d, logic [7:0] exp);
    int n = 0;
    @(posedge clock);
    io_wr_strobe <= 1;
    io_wr_data <= d;
    @(posedge clock);
    io_wr_strobe <= 0;
    repeat (22) begin
      @(negedge clock);
      n += warm_restart_out;
    end
    chk(n, exp);
  endtask : wr92
  initial begin
    int n = 0;
    logic od;
    repeat (10) @(posedge clock);
    rstn <= 1;
    power_good_in <= 1;
    while (cpu_hard_reset_out !== 1'b0 && n < 99) begin
      @(posedge clock);
      n++;
    end
    chk(n >= 20 && n < 99, 1);
    if (n >= 99) summarize();
    clock_dir_strap <= 0;
    wr92(8'h01, 16);
    wr92(8'h01, 0);
    wr92(8'h00, 0);
    wr92(8'h01, 16);
    chk(local_bus_clock_oe, 1);
    // shutdown corner case: special cycle with only byte lane 0 enabled
    @(posedge clock);
    req <= 1;
    bus <= 11'h1FE;
    @(posedge clock);
    req <= 0;
    @(posedge clock);
    @(negedge clock);
    chk({shutdown_seen, warm_restart_out, cycle_type}, 8'h19);
    n = 0;
    od = timer_osc_div_out;
    repeat (96) begin
      @(posedge clock);
      n += timer_osc_div_out != od;
      od = timer_osc_div_out;
    end
    chk(n, 2);
    repeat (400) begin
      @(posedge clock);
      chk(byte_lane_enables_n_out, dma_cycle | master_cycle ? be_drive_n : 8'hFF);
      chk({addr_snoop_oe, addr_hi_out}, {dma_cycle, addr_hi_dma});
      chk(addr_mid_out[7:0], addr_mid_dma[7:0]);
      sd = lfsr(sd);
      {req, dma_cycle, master_cycle, be_drive_n, low_region_n} <= sd[11:0];
      {addr_hi_dma, addr_mid_dma} <= sd[27:16];
      bus <= sd[14:12] == 0 ? 11'h1FE : sd[26:16];
      kbd_reset_req <= sd[31:27] == 0;
    end
    power_good_in <= 0;
    repeat (4) @(posedge clock);
    chk(cpu_hard_reset_out, 1);
    summarize();
  end
endmodule : scf_front_test
